// *** bench/ext_bus_device.sv ***
module ext_bus_device (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [15:0] pull_low_in,
   output logic      [15:0] data_strap_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [2:0] hold_reg;

   // pulls must outlast the strap sampling window after release
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hold_reg <= 3'h0;
      end else if (hold_reg != 3'h7) begin
         hold_reg <= hold_reg + 3'h1;
      end
   end

   // weak pull-ups keep lines high unless the device pulls them, in reset and for 7 cycles after release
   assign data_strap_out = (hold_reg != 3'h7) ? ~pull_low_in : 16'hffff;
endmodule : ext_bus_device

// *** bench/tb_chip_select_unit.sv ***
module tb_chip_select_unit;
   timeunit 1ns;
   timeprecision 1ns;
   import chip_sel_pkg::*;

   localparam int BUS_LEN = 18;
   localparam logic [17:0] EMUL_PAGE_T = 18'h3ffe8;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic [5:0]  reg_addr_in = 6'h00;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic [1:0]  mode_strap_in = 2'h1;
   logic        bus_as_in = 1'b0;
   logic        bus_ds_in = 1'b0;
   logic [23:0] bus_addr_in = 24'h000000;
   logic [1:0]  bus_space_in = 2'h1;
   logic        bus_read_in = 1'b1;
   logic        bus_ube_in = 1'b0;
   logic        bus_lbe_in = 1'b0;
   logic [15:0] pull_low = 16'h0000;
   logic [15:0] data_strap_in;
   logic [15:0] reg_rdata_out;
   logic [11:0] pin_level_out;
   logic [11:0] pin_alt_out;
   logic        transfer_size_ack_out;
   logic        autovector_request_out;
   logic        module_mute_out;
   logic [11:0] pin_at1;
   logic [11:0] pin_end;
   logic [11:0] pin_after;
   logic        mute_at1;
   logic        prev;
   int          ack_at;
   int          autovector_request_at;
   int          toggles;
   int          low4;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          wsl[5] = '{0, 1, 13, 14, 15};

   always #10 clk_in = ~clk_in;

   chip_select_unit #(.SLOW_PERIPHERAL_CLOCK_HALF(8'h02)) dut (
      .clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
      .mode_strap_in, .data_strap_in, .bus_as_in, .bus_ds_in, .bus_addr_in, .bus_space_in,
      .bus_read_in, .bus_ube_in, .bus_lbe_in, .pin_level_out, .pin_alt_out, .transfer_size_ack_out,
      .autovector_request_out, .module_mute_out);

   ext_bus_device far_end (.clk_in, .rstn_in, .pull_low_in(pull_low), .data_strap_out(data_strap_in));

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chkb(input logic got, input logic exp);
      chk({23'h0, got}, {23'h0, exp});
   endtask : chkb

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk({8'h0, reg_rdata_out}, {8'h0, exp});
   endtask : rd

   task automatic do_reset(input logic [1:0] m, input logic [15:0] pull);
      @(posedge clk_in);
      rstn_in <= 1'b0;
      mode_strap_in <= m;
      pull_low <= pull;
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask : do_reset

   // one bus cycle: strobes high BUS_LEN cycles, then one idle cycle
   task automatic bus_cycle(input logic [23:0] a, input logic [1:0] sp, input logic r, input logic [1:0] ln);
      ack_at = 0;
      autovector_request_at = 0;
      low4 = 0;
      @(posedge clk_in);
      bus_as_in <= 1'b1;
      bus_ds_in <= 1'b1;
      bus_addr_in <= a;
      bus_space_in <= sp;
      bus_read_in <= r;
      {bus_ube_in, bus_lbe_in} <= ln;
      for (int k = 1; k <= BUS_LEN; k++) begin
         @(posedge clk_in);
         if (k == BUS_LEN) begin
            bus_as_in <= 1'b0;
            bus_ds_in <= 1'b0;
         end
         #1;
         if (transfer_size_ack_out === 1'b1 && ack_at == 0) ack_at = k;
         if (autovector_request_out === 1'b1 && autovector_request_at == 0) autovector_request_at = k;
         if (pin_level_out[4] === 1'b0) low4++;
         if (k == 1) begin
            pin_at1 = pin_level_out;
            mute_at1 = module_mute_out;
         end
      end
      pin_end = pin_level_out;
      @(posedge clk_in);
      #1;
      pin_after = pin_level_out;
   endtask : bus_cycle

   initial begin
      repeat (60000) @(posedge clk_in);
      n_mismatch++;
      complete_run();
   end

   initial begin
      do_reset(2'h1, 16'h0000);
      rd(OFS_PFN_LO, 16'h265a);
      rd(OFS_PFN_HI, 16'h02aa);
      rd(6'h10, 16'h0007);
      rd(6'h20, 16'h7b70);
      bus_cycle(24'h000100, 2'h1, 1'b1, 2'h3);
      chkb(pin_at1[0], 1'b0);
      chk(24'(ack_at), 24'd15);
      chkb(pin_end[0], 1'b0);
      chkb(pin_after[0], 1'b1);
      wr(6'h14, 16'h1403);
      wr(6'h24, 16'h1830);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h3);
      chkb(pin_at1[4], 1'b1);
      wr(OFS_PFN_LO, 16'h265a);
      bus_cycle(24'h14fffe, 2'h1, 1'b1, 2'h3);
      chkb(pin_at1[4], 1'b0);
      chk(24'(ack_at), 24'd2);
      chk(24'(low4), 24'd18);
      bus_cycle(24'h150000, 2'h1, 1'b1, 2'h3);
      chkb(pin_at1[4], 1'b1);
      wr(6'h17, 16'h1403);
      wr(6'h27, 16'h1830);
      wr(OFS_PFN_HI, 16'h02aa);
      bus_cycle(24'h140010, 2'h2, 1'b0, 2'h3);
      chk({12'h0, pin_at1 & 12'h090}, 24'h0);
      wr(6'h17, 16'h2003);
      foreach (wsl[i]) begin
         wr(6'h24, 16'h1830 | (16'(wsl[i]) << 6));
         bus_cycle(24'h140000, 2'h1, 1'b1, 2'h3);
         chk(24'(ack_at), (wsl[i] < 14) ? 24'(wsl[i] + 2) : ((wsl[i] == 14) ? 24'd1 : 24'd0));
      end
      wr(6'h24, 16'h1030);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h3);
      chkb(pin_at1[4], 1'b1);
      bus_cycle(24'h140000, 2'h1, 1'b0, 2'h3);
      chkb(pin_at1[4], 1'b0);
      wr(6'h24, 16'h1810);
      bus_cycle(24'h140000, 2'h2, 1'b1, 2'h3);
      chkb(pin_at1[4], 1'b1);
      wr(OFS_PFN_LO, 16'h275a);
      wr(6'h24, 16'h3830);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h2);
      chkb(pin_at1[4], 1'b1);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h1);
      chkb(pin_at1[4], 1'b0);
      wr(6'h24, 16'h5830);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h2);
      chkb(pin_at1[4], 1'b0);
      wr(6'h24, 16'h1830);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h3);
      chkb(pin_at1[4], 1'b1);
      wr(OFS_PFN_LO, 16'h265a);
      wr(6'h24, 16'h9830);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h3);
      chkb(low4 >= 8 && low4 <= 10, 1'b1);
      chk(24'(ack_at), 24'd0);
      wr(6'h24, 16'h1807);
      bus_cycle(24'h140006, 2'h0, 1'b1, 2'h3);
      chk({pin_at1[4], 23'(autovector_request_at)}, 24'd1);
      bus_cycle(24'h140004, 2'h0, 1'b1, 2'h3);
      chk({pin_at1[4], 23'(autovector_request_at)}, 24'h800000);
      wr(6'h24, 16'h1830);
      wr(OFS_PFN_LO, 16'h245a);
      wr(OFS_PDR, 16'h0001);
      repeat (2) @(posedge clk_in);
      #1;
      chkb(pin_level_out[4], 1'b1);
      wr(OFS_PDR, 16'h0000);
      bus_cycle(24'h140000, 2'h1, 1'b1, 2'h3);
      chkb(pin_at1[4], 1'b0);
      chk(24'(ack_at), 24'd0);
      wr(OFS_PFN_LO, 16'hffff);
      rd(OFS_PFN_LO, 16'h37ff);
      wr(OFS_PFN_HI, 16'hffff);
      rd(OFS_PFN_HI, 16'h03ff);
      rd(6'h3f, 16'h0000);
      wr(OFS_PFN_HI, 16'h0000);
      #1;
      toggles = 0;
      prev = pin_level_out[11];
      repeat (20) begin
         @(posedge clk_in);
         #1;
         if (pin_level_out[11] !== prev) toggles++;
         prev = pin_level_out[11];
      end
      chkb(toggles >= 8, 1'b1);
      do_reset(2'h0, 16'h0000);
      rd(OFS_PFN_LO, 16'h005f);
      rd(OFS_PFN_HI, 16'h0300);
      chkb(pin_alt_out[2], 1'b1);
      do_reset(2'h2, 16'h0004);
      rd(OFS_PFN_LO, 16'h15f7);
      rd(OFS_PFN_HI, 16'h03ff);
      do_reset(2'h3, 16'h0000);
      bus_cycle({EMUL_PAGE_T, 6'h00}, 2'h2, 1'b1, 2'h3);
      chkb(mute_at1, 1'b1);
      chk(24'(ack_at), 24'd2);
      chkb(pin_at1[3], 1'b0);
      complete_run();
   end

endmodule : tb_chip_select_unit

// *** verilog/chip_sel_pkg.sv ***
package chip_sel_pkg;
   localparam int          NPIN          = 12;
   // register index on the 6-bit register port
   localparam logic [5:0]  OFS_PFN_LO    = 6'h00;
   localparam logic [5:0]  OFS_PFN_HI    = 6'h01;
   localparam logic [5:0]  OFS_PDR       = 6'h02;
   localparam logic [5:0]  OFS_STAT      = 6'h03;
   localparam logic [1:0]  GRP_BASE      = 2'h1;
   localparam logic [1:0]  GRP_OPT       = 2'h2;
   // reset values and pin function write masks
   localparam logic [15:0] BOOT_BASE_RST = 16'h0007;
   localparam logic [15:0] BOOT_OPT_RST  = 16'h7b70;
   localparam logic [15:0] PFL_PARTIAL   = 16'h265a;
   localparam logic [15:0] PFL_FULL_FIX  = 16'h1556;
   localparam logic [15:0] PFL_SINGLE    = 16'h005f;
   localparam logic [15:0] PFH_PARTIAL   = 16'h02aa;
   localparam logic [15:0] PFH_FULL_FIX  = 16'h0155;
   localparam logic [15:0] PFH_SINGLE    = 16'h0300;
   localparam logic [15:0] PFL_WMASK     = 16'h37ff;
   localparam logic [15:0] PFH_WMASK     = 16'h03ff;
   // pin indices
   localparam int          PIN_EMUL      = 3;
   localparam int          PIN_FC1       = 5;
   localparam int          PIN_TOP       = 11;
   localparam int          PDR_FIRST     = 4;
   // pin function codes
   localparam logic [1:0]  FN_DISC       = 2'h0;
   localparam logic [1:0]  FN_ALT        = 2'h1;
   localparam logic [1:0]  FN_CS8        = 2'h2;
   localparam logic [1:0]  FN_CS16       = 2'h3;
   // option register field positions, ack codes, emulator ack limit, strap load delay and bus space codes
   localparam int          OPT_MODE      = 15;
   localparam int          OPT_BYTE      = 13;
   localparam int          OPT_RW        = 11;
   localparam int          OPT_STRB      = 10;
   localparam int          OPT_TRANSFER_SIZE_ACK     = 6;
   localparam int          OPT_SPACE     = 4;
   localparam int          OPT_IPL       = 1;
   localparam int          OPT_AUTOVECTOR_REQUEST      = 0;
   localparam logic [3:0]  TRANSFER_SIZE_ACK_FAST    = 4'he;
   localparam logic [3:0]  TRANSFER_SIZE_ACK_EXT     = 4'hf;
   localparam logic [3:0]  EMUL_ACK_LIM  = 4'h1;
   localparam logic [1:0]  INIT_CYC      = 2'h2;
   localparam logic [1:0]  SP_CPU        = 2'h0;
   localparam logic [1:0]  SP_USER       = 2'h1;
   localparam logic [1:0]  SP_SUPER      = 2'h2;

   typedef enum logic [1:0] {
      MODE_SINGLE  = 2'b00,
      MODE_PARTIAL = 2'b01,
      MODE_FULL    = 2'b10,
      MODE_EMUL    = 2'b11
   } op_mode_e;

   typedef enum logic {
      ACK_IDLE  = 1'b0,
      ACK_COUNT = 1'b1
   } ack_e;

   typedef struct packed {
      logic [15:0]       pfl;
      logic [15:0]       pfh;
      logic [6:0]        pdr;
      logic [11:0][15:0] base;
      logic [11:0][15:0] opt;
      logic [11:0]       size_set;
      logic [11:0]       sel_act;
      logic [11:0]       pin_level;
      logic [11:0]       pin_alt;
      logic [1:0]        init_cnt;
      logic              init_done;
      op_mode_e          mode;
      logic [15:0]       dsync1;
      logic [15:0]       dsync2;
      logic [1:0]        msync1;
      logic [1:0]        msync2;
      logic              as_prev;
      ack_e              ack;
      logic [3:0]        ack_cnt;
      logic [3:0]        ack_lim;
      logic              transfer_size_ack;
      logic              autovector_request;
      logic              mute;
      logic              slow_peripheral_clock;
      logic [7:0]        ecnt;
      logic [15:0]       rdata;
   } state_s;
endpackage : chip_sel_pkg

// *** verilog/chip_select_unit.sv ***
// The register addresses and the plain strobed port are this design's own decisions.
module chip_select_unit #(
   parameter logic [7:0]  SLOW_PERIPHERAL_CLOCK_HALF = 8'h04,
   parameter logic [17:0] EMUL_PAGE = 18'h3ffe8
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [5:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic [1:0]  mode_strap_in,
   input  wire logic [15:0] data_strap_in,
   input  wire logic        bus_as_in,
   input  wire logic        bus_ds_in,
   input  wire logic [23:0] bus_addr_in,
   input  wire logic [1:0]  bus_space_in,
   input  wire logic        bus_read_in,
   input  wire logic        bus_ube_in,
   input  wire logic        bus_lbe_in,
   output logic      [11:0] pin_level_out,
   output logic      [11:0] pin_alt_out,
   output logic             transfer_size_ack_out,
   output logic             autovector_request_out,
   output logic             module_mute_out
);
   import chip_sel_pkg::*;

   state_s st_reg;
   state_s st_next;

   function automatic logic blk_hit(input logic [15:0] base, input logic [23:0] a);
      logic [12:0] m;
      case (base[2:0])
         3'h0:    m = 13'h1fff;
         3'h1:    m = 13'h1ffc;
         3'h2:    m = 13'h1ff8;
         3'h3:    m = 13'h1fe0;
         3'h4:    m = 13'h1fc0;
         3'h5:    m = 13'h1f80;
         3'h6:    m = 13'h1f00;
         default: m = 13'h1e00;
      endcase
      return ((a[23:11] ^ base[15:3]) & m) == 13'h0000;
   endfunction : blk_hit

   function automatic logic attr_hit(input logic [15:0] o, input logic [1:0] sp, input logic rd,
                                     input logic [2:0] lvl, input logic ub, input logic lb,
                                     input logic wide);
      logic sp_ok;
      logic rw_ok;
      logic by_ok;
      case (o[OPT_SPACE+:2])
         2'h0:    sp_ok = (sp == SP_CPU) && (o[OPT_IPL+:3] == 3'h0 || o[OPT_IPL+:3] == lvl);
         2'h1:    sp_ok = (sp == SP_USER);
         2'h2:    sp_ok = (sp == SP_SUPER);
         default: sp_ok = (sp != SP_CPU);
      endcase
      rw_ok = rd ? o[OPT_RW] : o[OPT_RW+1];
      by_ok = !wide || (o[OPT_BYTE] && lb) || (o[OPT_BYTE+1] && ub);
      return sp_ok && rw_ok && by_ok;
   endfunction : attr_hit

   function automatic logic [1:0] pin_fn(input logic [15:0] lo, input logic [15:0] hi, input int i);
      if (i == PIN_FC1) begin
         return lo[10] ? FN_ALT : FN_DISC;
      end else if (i < PIN_FC1) begin
         return lo[2*i+:2];
      end else if (i == PIN_FC1 + 1) begin
         return lo[13:12];
      end else begin
         return hi[2*(i-7)+:2];
      end
   endfunction : pin_fn

   logic [11:0] cand;
   logic        emul_hit;
   logic        emul_go;
   logic        as_rise;

   always_comb begin
      logic [1:0]  fld;
      logic        strobe;
      logic        match;
      logic [15:0] full_lo;
      logic [15:0] full_hi;
      int          pick;
      logic [11:0] pdr_pins;
      fld = FN_DISC;
      strobe = 1'b0;
      match = 1'b0;
      full_lo = PFL_FULL_FIX;
      full_hi = PFH_FULL_FIX;
      pick = -1;
      // discrete levels by pin index; low pins and top pin stay high here
      pdr_pins = {1'b1, st_reg.pdr, {PDR_FIRST{1'b1}}};
      st_next = st_reg;
      cand = '0;
      st_next.transfer_size_ack = 1'b0;
      st_next.autovector_request = 1'b0;
      st_next.rdata = 16'h0000;
      st_next.as_prev = bus_as_in;
      as_rise = bus_as_in && !st_reg.as_prev;

      // strap synchronisers and load after release
      st_next.dsync1 = data_strap_in;
      st_next.dsync2 = st_reg.dsync1;
      st_next.msync1 = mode_strap_in;
      st_next.msync2 = st_reg.msync1;
      if (!st_reg.init_done) begin
         if (st_reg.init_cnt == INIT_CYC) begin
            st_next.init_done = 1'b1;
            st_next.mode = op_mode_e'(st_reg.msync2);
            full_lo[13] = st_reg.dsync2[2];
            full_lo[9] = st_reg.dsync2[2];
            full_lo[7] = st_reg.dsync2[10];
            full_lo[5] = st_reg.dsync2[10];
            full_lo[3] = st_reg.dsync2[2];
            full_lo[0] = st_reg.dsync2[0];
            full_hi[9] = st_reg.dsync2[7];
            full_hi[7] = st_reg.dsync2[6];
            full_hi[5] = st_reg.dsync2[5];
            full_hi[3] = st_reg.dsync2[4];
            full_hi[1] = st_reg.dsync2[3];
            case (op_mode_e'(st_reg.msync2))
               MODE_SINGLE: begin
                  st_next.pfl = PFL_SINGLE;
                  st_next.pfh = PFH_SINGLE;
                  st_next.size_set = '1;
               end
               MODE_PARTIAL: begin
                  st_next.pfl = PFL_PARTIAL;
                  st_next.pfh = PFH_PARTIAL;
                  st_next.size_set = 12'h001;
               end
               default: begin
                  st_next.pfl = full_lo;
                  st_next.pfh = full_hi;
                  st_next.size_set = 12'h001;
               end
            endcase
         end else begin
            st_next.init_cnt = st_reg.init_cnt + 2'h1;
         end
      end

      // slow peripheral clock divider
      if (st_reg.ecnt == SLOW_PERIPHERAL_CLOCK_HALF - 8'h01) begin
         st_next.ecnt = 8'h00;
         st_next.slow_peripheral_clock = !st_reg.slow_peripheral_clock;
      end else begin
         st_next.ecnt = st_reg.ecnt + 8'h01;
      end

      // register port
      if (reg_wr_in) begin
         if (reg_addr_in == OFS_PFN_LO) begin
            st_next.pfl = reg_wdata_in & PFL_WMASK;
            st_next.size_set[6:0] = '1;
         end else if (reg_addr_in == OFS_PFN_HI) begin
            st_next.pfh = reg_wdata_in & PFH_WMASK;
            st_next.size_set[11:7] = '1;
         end else if (reg_addr_in == OFS_PDR) begin
            st_next.pdr = reg_wdata_in[6:0];
         end else if (reg_addr_in[5:4] == GRP_BASE && reg_addr_in[3:0] < 4'hc) begin
            st_next.base[reg_addr_in[3:0]] = reg_wdata_in;
         end else if (reg_addr_in[5:4] == GRP_OPT && reg_addr_in[3:0] < 4'hc) begin
            st_next.opt[reg_addr_in[3:0]] = reg_wdata_in;
         end
      end
      if (reg_rd_in) begin
         if (reg_addr_in == OFS_PFN_LO) begin
            st_next.rdata = st_reg.pfl;
         end else if (reg_addr_in == OFS_PFN_HI) begin
            st_next.rdata = st_reg.pfh;
         end else if (reg_addr_in == OFS_PDR) begin
            st_next.rdata = {9'h000, st_reg.pdr};
         end else if (reg_addr_in == OFS_STAT) begin
            st_next.rdata = {st_reg.sel_act, st_reg.ack, st_reg.init_done, st_reg.mode};
         end else if (reg_addr_in[5:4] == GRP_BASE && reg_addr_in[3:0] < 4'hc) begin
            st_next.rdata = st_reg.base[reg_addr_in[3:0]];
         end else if (reg_addr_in[5:4] == GRP_OPT && reg_addr_in[3:0] < 4'hc) begin
            st_next.rdata = st_reg.opt[reg_addr_in[3:0]];
         end
      end

      // emulator select: pin field only, no base or option
      emul_hit = (st_reg.mode == MODE_EMUL) && st_reg.init_done && bus_as_in
                 && (bus_addr_in[23:6] == EMUL_PAGE);
      emul_go = as_rise && emul_hit;
      st_next.mute = emul_hit;

      // per-pin matching, each circuit independent
      for (int i = 0; i < NPIN; i++) begin
         fld = pin_fn(st_reg.pfl, st_reg.pfh, i);
         strobe = st_reg.opt[i][OPT_STRB] ? bus_ds_in : bus_as_in;
         match = fld[1] && i != PIN_EMUL && i != PIN_FC1 && st_reg.init_done && st_reg.size_set[i]
                 && blk_hit(st_reg.base[i], bus_addr_in)
                 && attr_hit(st_reg.opt[i], bus_space_in, bus_read_in, bus_addr_in[3:1],
                             bus_ube_in, bus_lbe_in, fld == FN_CS16);
         cand[i] = match && bus_as_in;
         st_next.sel_act[i] = match && strobe
                              && (!st_reg.opt[i][OPT_MODE] || st_reg.slow_peripheral_clock);
         if (i == PIN_EMUL) begin
            st_next.sel_act[i] = fld[1] && emul_hit;
         end
         st_next.pin_alt[i] = (fld == FN_ALT);
         case (fld)
            FN_DISC: begin
               if (i == PIN_TOP) begin
                  st_next.pin_level[i] = st_reg.slow_peripheral_clock;
               end else begin
                  st_next.pin_level[i] = pdr_pins[i];
               end
            end
            FN_ALT: begin
               st_next.pin_level[i] = 1'b1;
            end
            default: begin
               st_next.pin_level[i] = !st_next.sel_act[i];
            end
         endcase
      end

      // lowest matching asynchronous circuit owns the ack
      for (int i = NPIN - 1; i >= 0; i--) begin
         if (cand[i] && !st_reg.opt[i][OPT_MODE]) begin
            pick = i;
         end
      end

      // shared acknowledge generator
      case (st_reg.ack)
         ACK_IDLE: begin
            if (emul_go) begin
               st_next.ack = ACK_COUNT;
               st_next.ack_cnt = 4'h1;
               st_next.ack_lim = EMUL_ACK_LIM;
            end else if (as_rise && pick >= 0) begin
               if (st_reg.opt[pick][OPT_AUTOVECTOR_REQUEST] && bus_space_in == SP_CPU) begin
                  st_next.autovector_request = 1'b1;
               end else if (st_reg.opt[pick][OPT_TRANSFER_SIZE_ACK+:4] == TRANSFER_SIZE_ACK_FAST) begin
                  st_next.transfer_size_ack = 1'b1;
               end else if (st_reg.opt[pick][OPT_TRANSFER_SIZE_ACK+:4] != TRANSFER_SIZE_ACK_EXT) begin
                  st_next.ack = ACK_COUNT;
                  st_next.ack_cnt = 4'h1;
                  st_next.ack_lim = st_reg.opt[pick][OPT_TRANSFER_SIZE_ACK+:4] + 4'h1;
               end
            end
         end
         ACK_COUNT: begin
            if (!bus_as_in) begin
               st_next.ack = ACK_IDLE;
            end else if (st_reg.ack_cnt == st_reg.ack_lim) begin
               st_next.transfer_size_ack = 1'b1;
               st_next.ack = ACK_IDLE;
            end else begin
               st_next.ack_cnt = st_reg.ack_cnt + 4'h1;
            end
         end
         default: begin
            st_next.ack = ACK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg <= '0;
         st_reg.pin_level <= '1;
         st_reg.base[0] <= BOOT_BASE_RST;
         st_reg.opt[0] <= BOOT_OPT_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_out = st_reg.rdata;
   assign pin_level_out = st_reg.pin_level;
   assign pin_alt_out = st_reg.pin_alt;
   assign transfer_size_ack_out = st_reg.transfer_size_ack;
   assign autovector_request_out = st_reg.autovector_request;
   assign module_mute_out = st_reg.mute;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   a_cycle_end_negate: assert property (!bus_as_in |=> st_reg.sel_act == 12'h000)
      else $error("select active after bus cycle end");
   a_size_gate: assert property (!st_reg.size_set[1] |=> !st_reg.sel_act[1])
      else $error("select asserted before size chosen");
   a_disc_inhibit: assert property (st_reg.pfl[3:2] == FN_DISC |=> !st_reg.sel_act[1])
      else $error("discrete pin still matching");
   a_unused_zero: assert property (st_reg.pfl[15:14] == 2'h0 && st_reg.pfl[11] == 1'b0
                                   && st_reg.pfh[15:10] == 6'h00)
      else $error("unused pin function bits set");
   a_top_clock: assert property ($past(rstn_in) && st_reg.pfh[9:8] == FN_DISC
                                 |=> pin_level_out[PIN_TOP] == $past(st_reg.slow_peripheral_clock))
      else $error("top pin not carrying slow clock");
   a_disc_drive: assert property ($past(rstn_in) && st_reg.pfl[9:8] == FN_DISC
                                  |=> pin_level_out[4] == $past(st_reg.pdr[0]))
      else $error("discrete pin not driving data");
   a_low_active: assert property (st_reg.sel_act[1] && st_reg.pfl[3] |-> !pin_level_out[1])
      else $error("active select not low");
   a_emul_three: assert property (emul_go && st_reg.ack == ACK_IDLE ##1 bus_as_in |=> transfer_size_ack_out)
      else $error("emulated access not three cycles");
   a_emul_mute: assert property (emul_hit |=> module_mute_out)
      else $error("module not muted on emulated access");
   a_wait_done: assert property (st_reg.ack == ACK_COUNT && st_reg.ack_cnt == st_reg.ack_lim
                                 && bus_as_in |=> transfer_size_ack_out && st_reg.ack == ACK_IDLE)
      else $error("ack not at programmed wait count");
   a_sync_gate: assert property (st_reg.opt[4][OPT_MODE] && !st_reg.slow_peripheral_clock |=> !st_reg.sel_act[4])
      else $error("synchronous select asserted off slow clock");
   a_no_stray_ack: assert property (st_reg.ack == ACK_IDLE && !emul_go && cand == 12'h000
                                    |=> !transfer_size_ack_out && !autovector_request_out)
      else $error("ack without a matching select");
   a_alt_level: assert property (st_reg.pin_alt[2] |-> pin_level_out[2])
      else $error("alternate pin not released high");
   a_emul_pin: assert property (emul_hit && st_reg.pfl[7] |=> st_reg.sel_act[PIN_EMUL])
      else $error("emulator select missing on mapped access");
   a_boot_live: assert property (st_reg.init_done |-> st_reg.size_set[0])
      else $error("boot select not enabled after reset");
   a_single_cfg: assert property ($rose(st_reg.init_done) && st_reg.mode == MODE_SINGLE
                                  |-> st_reg.pfl == PFL_SINGLE && st_reg.pfh == PFH_SINGLE)
      else $error("single-chip pin functions wrong");
   a_fc_pin: assert property (st_reg.pfl[10] |=> pin_alt_out[PIN_FC1])
      else $error("function-code pin not given its function");
   a_ack_abort: assert property (st_reg.ack == ACK_COUNT && !bus_as_in
                                 |=> st_reg.ack == ACK_IDLE && !transfer_size_ack_out)
      else $error("aborted cycle still acknowledged");
   a_transfer_size_ack_pulse: assert property (transfer_size_ack_out |=> !transfer_size_ack_out)
      else $error("ack longer than one cycle");
   a_low_byte: assert property (st_reg.pfl[9:8] == FN_CS16 && st_reg.opt[4][OPT_BYTE+:2] == 2'h0
                                |=> !st_reg.sel_act[4])
      else $error("disabled byte field still selecting");
   a_mute_low: assert property (!emul_hit |=> !module_mute_out)
      else $error("module muted outside mapped access");
   a_autovector_request_cpu: assert property (autovector_request_out |-> $past(bus_space_in) == SP_CPU)
      else $error("autovector outside CPU space");

   c_transfer_size_ack: cover property (as_rise ##[1:16] transfer_size_ack_out);
   c_autovector_request: cover property (autovector_request_out);
   c_emul: cover property (emul_go ##2 transfer_size_ack_out);
   c_sync: cover property (st_reg.opt[4][OPT_MODE] && st_reg.sel_act[4]);
   c_wide: cover property (st_reg.pfl[9:8] == FN_CS16 && st_reg.sel_act[4]);
endmodule : chip_select_unit
